// ---- dams_pkg.sv ----
// Constants and types shared by the dual analog monitor scaler
// Overview of operation
// - Two channels, own selector, offset and scale
// - Outputs held within plus/minus ten volts
// - Mode one outputs magnitude on both channels
// - Codes 0-7 drive variables, code 8 reserved
// - Codes 9-24 encoder, inertia, error, thermal, current, position, speed, hall items
// - Channel one: (variable - offset) / scale
// - Channel two: (variable - offset) / scale
package dams_pkg;
  // Register indexes; the byte address is four times the index
  localparam logic [15:0] IDX_MODE = 16'h2220;
  localparam logic [15:0] IDX_SEL1 = 16'h2221;
  localparam logic [15:0] IDX_SEL2 = 16'h2222;
  localparam logic [15:0] IDX_OFF1 = 16'h2223;
  localparam logic [15:0] IDX_OFF2 = 16'h2224;
  localparam logic [15:0] IDX_SCL1 = 16'h2225;
  localparam logic [15:0] IDX_SCL2 = 16'h2226;
  // APB byte addresses, one aligned word per register
  localparam logic [15:0] ADDR_MODE = 16'(IDX_MODE * 4);
  localparam logic [15:0] ADDR_SEL1 = 16'(IDX_SEL1 * 4);
  localparam logic [15:0] ADDR_SEL2 = 16'(IDX_SEL2 * 4);
  localparam logic [15:0] ADDR_OFF1 = 16'(IDX_OFF1 * 4);
  localparam logic [15:0] ADDR_OFF2 = 16'(IDX_OFF2 * 4);
  localparam logic [15:0] ADDR_SCL1 = 16'(IDX_SCL1 * 4);
  localparam logic [15:0] ADDR_SCL2 = 16'(IDX_SCL2 * 4);
  // Reset values
  localparam logic [15:0] RST_MODE = 16'h0000;
  localparam logic [15:0] RST_SEL = 16'h0000;
  localparam logic [31:0] RST_OFFSET = 32'h0000_0000;
  localparam logic [31:0] RST_SCALE = 32'h0000_0001;
  // Field values
  localparam logic [15:0] MODE_ABS = 16'h0001;
  localparam logic [15:0] SEL_LAST = 16'h0018;
  localparam int SEL_RESERVED = 8;
  localparam int NUM_CODES = 25;
  // Datapath widths
  localparam int VAL_W = 32;
  localparam int NUM_W = 43;
  localparam int OUT_W = 16;
  // Output scaling in millivolts
  localparam int FULL_SCALE_V = 10;
  localparam logic [NUM_W-1:0] MV_PER_V = 43'h3e8;
  localparam logic [NUM_W-1:0] LIMIT_MV = NUM_W'(FULL_SCALE_V) * MV_PER_V;
  // Divider runs one clock per quotient bit
  localparam int DIV_CYCLES = NUM_W;
  // Conversion sequence shared by both channels
  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b00,
    ST_START = 2'b01,
    ST_DIVIDE = 2'b10,
    ST_LOAD = 2'b11
  } dams_state_e;
endpackage

// ---- dams_divider.sv ----
// Restoring unsigned divider, one quotient bit per clock
module dams_divider
  import dams_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [NUM_W-1:0] num,
  input wire logic [VAL_W-1:0] den,
  output logic done,
  output logic [NUM_W-1:0] quot
);
  logic [VAL_W:0] rem; // Partial remainder, below the divisor whenever the divisor is nonzero
  logic [VAL_W-1:0] den_q; // Divisor held for the whole run
  logic [5:0] cnt; // Iteration counter
  logic busy; // Run in progress
  logic [VAL_W+1:0] shifted; // Remainder with next numerator bit
  logic [VAL_W+1:0] trial; // Shifted remainder minus divisor
  logic fits; // Divisor fits, quotient bit is one
  logic last; // Final iteration

  // A zero divisor fits on the first 33 bits, so the upper quotient bits are all ones
  assign shifted = {rem, quot[NUM_W-1]};
  assign trial = shifted - {2'b00, den_q};
  assign fits = ~trial[VAL_W+1];
  assign last = (cnt == 6'(DIV_CYCLES - 1));

  // Quotient bits shift in where numerator bits shift out
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rem <= '0;
      den_q <= '0;
      quot <= '0;
      cnt <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else if (start)
    begin
      rem <= '0;
      den_q <= den;
      quot <= num;
      cnt <= '0;
      busy <= 1'b1;
      done <= 1'b0;
    end
    else if (busy)
    begin
      rem <= fits ? trial[VAL_W:0] : shifted[VAL_W:0];
      quot <= {quot[NUM_W-2:0], fits};
      cnt <= cnt + 6'h01;
      busy <= !last;
      done <= last;
    end
    else
    begin
      done <= 1'b0;
    end
  end

  AST_DIV_DONE: assert property (@(posedge clk) disable iff (!rst_b) start |-> ##44 done)
    else $error("Divider did not finish in 44 cycles");
endmodule // dams_divider

// ---- dams_limiter.sv ----
// Output limiter with sign and magnitude mode
module dams_limiter
  import dams_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [NUM_W-1:0] quot,
  input wire logic neg,
  input wire logic abs_mode,
  output logic signed [OUT_W-1:0] out_mv
);
  localparam logic signed [OUT_W-1:0] LIM_S = LIMIT_MV[OUT_W-1:0]; // Full scale
  logic [OUT_W-1:0] mag; // Clamped magnitude
  logic [OUT_W-1:0] next_out_mv; // Signed result to load

  // Clamp before the sign is applied, so both polarities stop at full scale
  assign mag = (quot > LIMIT_MV) ? LIMIT_MV[OUT_W-1:0] : quot[OUT_W-1:0];
  // Magnitude mode drops the sign on every channel
  assign next_out_mv = (neg && !abs_mode) ? (~mag + 16'h0001) : mag;

  // Output holds between refreshes
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      out_mv <= '0;
    else if (load)
      out_mv <= next_out_mv;
  end

  AST_RANGE: assert property (@(posedge clk) disable iff (!rst_b)
    (out_mv <= LIM_S) && (out_mv >= -LIM_S))
    else $error("Monitor output beyond full scale");
  AST_CLAMP: assert property (@(posedge clk) disable iff (!rst_b)
    (load && (quot > LIMIT_MV)) |=> ((out_mv == LIM_S) || (out_mv == -LIM_S)))
    else $error("Overrange result not clamped to full scale");
  AST_ABS: assert property (@(posedge clk) disable iff (!rst_b)
    (load && abs_mode) |=> (out_mv >= 0))
    else $error("Negative output in magnitude mode");
endmodule // dams_limiter

// ---- dams_scaler.sv ----
// Dual analog monitor scaler: APB registers, selectors and scaling
module dams_scaler
  import dams_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic signed [VAL_W-1:0] VAR_SPEED_FB,
  input wire logic signed [VAL_W-1:0] VAR_SPEED_CMD,
  input wire logic signed [VAL_W-1:0] VAR_SPEED_ERR,
  input wire logic signed [VAL_W-1:0] VAR_TORQUE_FB,
  input wire logic signed [VAL_W-1:0] VAR_TORQUE_CMD,
  input wire logic signed [VAL_W-1:0] VAR_POS_ERR,
  input wire logic signed [VAL_W-1:0] VAR_OVERLOAD,
  input wire logic signed [VAL_W-1:0] VAR_LINK_VOLT,
  input wire logic signed [VAL_W-1:0] VAR_ENC_TURN,
  input wire logic signed [VAL_W-1:0] VAR_INERTIA,
  input wire logic signed [VAL_W-1:0] VAR_FOLLOW_ERR,
  input wire logic signed [VAL_W-1:0] VAR_DRV_TEMP1,
  input wire logic signed [VAL_W-1:0] VAR_DRV_TEMP2,
  input wire logic signed [VAL_W-1:0] VAR_ENC_TEMP,
  input wire logic signed [VAL_W-1:0] VAR_HALL,
  input wire logic signed [VAL_W-1:0] VAR_CUR_U,
  input wire logic signed [VAL_W-1:0] VAR_CUR_V,
  input wire logic signed [VAL_W-1:0] VAR_CUR_W,
  input wire logic signed [VAL_W-1:0] VAR_POS_ACT,
  input wire logic signed [VAL_W-1:0] VAR_POS_DMD,
  input wire logic signed [VAL_W-1:0] VAR_CMD_SPEED,
  input wire logic signed [VAL_W-1:0] VAR_HALL_U,
  input wire logic signed [VAL_W-1:0] VAR_HALL_V,
  input wire logic signed [VAL_W-1:0] VAR_HALL_W,
  output logic signed [OUT_W-1:0] MON_CH1_MV,
  output logic signed [OUT_W-1:0] MON_CH2_MV,
  output logic MON_UPDATE
);
  // Byte-lane merge of write data into a register word
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] st
  );
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
      if (st[b])
        res[8*b +: 8] = wd[8*b +: 8];
    return res;
  endfunction

  logic signed [VAL_W-1:0] var_tab [NUM_CODES]; // Code table of variables
  logic [15:0] mode; // Output mode setting
  logic [31:0] wd_mode; // Merged write word for mode
  logic wr_acc; // Write access phase
  logic setup; // Setup phase of any transfer
  logic hit_mode; // Mode register addressed
  logic hit_any; // Any register addressed
  logic [31:0] rd_mux; // Read word before capture
  logic abs_mode; // Magnitude-only output selected
  logic div_done_all; // Both dividers finished
  dams_state_e state; // Conversion sequence state
  dams_state_e next_state; // Next sequence state

  // Variables that only the selectors read come from the same clock
  // domain, so no synchroniser is needed; slot 8 reads as zero.
  assign var_tab[0] = VAR_SPEED_FB;
  assign var_tab[1] = VAR_SPEED_CMD;
  assign var_tab[2] = VAR_SPEED_ERR;
  assign var_tab[3] = VAR_TORQUE_FB;
  assign var_tab[4] = VAR_TORQUE_CMD;
  assign var_tab[5] = VAR_POS_ERR;
  assign var_tab[6] = VAR_OVERLOAD;
  assign var_tab[7] = VAR_LINK_VOLT;
  assign var_tab[SEL_RESERVED] = '0;
  assign var_tab[9] = VAR_ENC_TURN;
  assign var_tab[10] = VAR_INERTIA;
  assign var_tab[11] = VAR_FOLLOW_ERR;
  assign var_tab[12] = VAR_DRV_TEMP1;
  assign var_tab[13] = VAR_DRV_TEMP2;
  assign var_tab[14] = VAR_ENC_TEMP;
  assign var_tab[15] = VAR_HALL;
  assign var_tab[16] = VAR_CUR_U;
  assign var_tab[17] = VAR_CUR_V;
  assign var_tab[18] = VAR_CUR_W;
  assign var_tab[19] = VAR_POS_ACT;
  assign var_tab[20] = VAR_POS_DMD;
  assign var_tab[21] = VAR_CMD_SPEED;
  assign var_tab[22] = VAR_HALL_U;
  assign var_tab[23] = VAR_HALL_V;
  assign var_tab[24] = VAR_HALL_W;

  // Bus decode; zero wait states, so the access phase always completes
  assign setup = PSEL & ~PENABLE;
  assign wr_acc = PSEL & PENABLE & PWRITE;
  assign hit_mode = (PADDR == ADDR_MODE);
  assign wd_mode = merge({16'h0000, mode}, PWDATA, PSTRB);
  assign PREADY = 1'b1;
  assign abs_mode = (mode == MODE_ABS);

  // Mode register; other mode values keep the signed output
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
      mode <= RST_MODE;
    else if (wr_acc && hit_mode)
      mode <= wd_mode[15:0];
  end

  // One channel per iteration, each with its own settings and datapath
  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    logic [15:0] sel; // Variable selector
    logic [31:0] off; // Signed offset
    logic [31:0] scl; // Unsigned scale
    logic hit_sel; // Selector addressed
    logic hit_off; // Offset addressed
    logic hit_scl; // Scale addressed
    logic [31:0] wd_sel; // Merged write words
    logic [31:0] wd_off;
    logic [31:0] wd_scl;
    logic [31:0] rd; // This channel's read contribution
    logic signed [VAL_W-1:0] val; // Selected variable
    logic signed [VAL_W:0] diff; // Variable minus offset
    logic [VAL_W:0] mag; // Magnitude of the difference
    logic [NUM_W-1:0] num_calc; // Magnitude in millivolt units
    logic [NUM_W-1:0] num_q; // Dividend held for the run
    logic [VAL_W-1:0] den_q; // Scale held for the run
    logic neg_q; // Sign of the difference
    logic lt; // Variable below offset, for checking only
    logic done; // Divider finished
    logic [NUM_W-1:0] quot; // Divider result
    logic signed [OUT_W-1:0] out_mv; // Limited output
    logic [NUM_W+VAL_W-1:0] prod; // Quotient times scale, for checking
    logic quot_ok; // Quotient consistent with dividend and scale

    assign hit_sel = (PADDR == ((c == 0) ? ADDR_SEL1 : ADDR_SEL2));
    assign hit_off = (PADDR == ((c == 0) ? ADDR_OFF1 : ADDR_OFF2));
    assign hit_scl = (PADDR == ((c == 0) ? ADDR_SCL1 : ADDR_SCL2));
    assign wd_sel = merge({16'h0000, sel}, PWDATA, PSTRB);
    assign wd_off = merge(off, PWDATA, PSTRB);
    assign wd_scl = merge(scl, PWDATA, PSTRB);
    // Narrow selector reads with zero upper half
    assign rd = hit_sel ? {16'h0000, sel} : hit_off ? off : hit_scl ? scl : 32'h0;

    // Both channels index the same table; codes past the end read zero
    assign val = (sel <= SEL_LAST) ? var_tab[sel[4:0]] : '0;
    // Difference is one bit wider so no offset can wrap it
    assign diff = (VAL_W+1)'(val) - (VAL_W+1)'($signed(off));
    assign mag = diff[VAL_W] ? (VAL_W+1)'(-diff) : diff;
    // Scaling to millivolts before the divide keeps fractional volts
    assign num_calc = NUM_W'(mag) * MV_PER_V;
    assign lt = (val < $signed(off));
    assign prod = quot * den_q;
    assign quot_ok = (prod <= {32'h0, num_q}) && (({32'h0, num_q} - prod) < {43'h0, den_q});

    // Settings registers
    always_ff @(posedge CLK_SYS)
    begin
      if (!RST_B)
      begin
        sel <= RST_SEL;
        off <= RST_OFFSET;
        scl <= RST_SCALE;
      end
      else if (wr_acc)
      begin
        if (hit_sel)
          sel <= wd_sel[15:0];
        if (hit_off)
          off <= wd_off;
        if (hit_scl)
          scl <= wd_scl;
      end
    end

    // Operands are frozen at sampling so a write mid-run does no harm
    always_ff @(posedge CLK_SYS)
    begin
      if (!RST_B)
      begin
        num_q <= '0;
        den_q <= RST_SCALE;
        neg_q <= 1'b0;
      end
      else if (state == ST_SAMPLE)
      begin
        num_q <= num_calc;
        den_q <= scl;
        neg_q <= diff[VAL_W];
      end
    end

    // Divide by the scale setting
    dams_divider u_div (
      .clk(CLK_SYS),
      .rst_b(RST_B),
      .start(state == ST_START),
      .num(num_q),
      .den(den_q),
      .done(done),
      .quot(quot)
    );

    // Clamp, sign and hold the result
    dams_limiter u_lim (
      .clk(CLK_SYS),
      .rst_b(RST_B),
      .load(state == ST_LOAD),
      .quot(quot),
      .neg(neg_q),
      .abs_mode(abs_mode),
      .out_mv(out_mv)
    );
  end

  assign hit_any = hit_mode | g_chan[0].hit_sel | g_chan[0].hit_off | g_chan[0].hit_scl
    | g_chan[1].hit_sel | g_chan[1].hit_off | g_chan[1].hit_scl;
  assign rd_mux = (hit_mode ? {16'h0000, mode} : 32'h0) | g_chan[0].rd | g_chan[1].rd;
  assign div_done_all = g_chan[0].done & g_chan[1].done;
  assign MON_CH1_MV = g_chan[0].out_mv;
  assign MON_CH2_MV = g_chan[1].out_mv;

  // Read data and error are captured in the setup phase
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
    end
    else if (setup)
    begin
      PRDATA <= PWRITE ? 32'h0 : rd_mux;
      PSLVERR <= ~hit_any;
    end
  end

  // Sequence: sample operands, start divide, wait, load outputs
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_SAMPLE: next_state = ST_START;
      ST_START: next_state = ST_DIVIDE;
      ST_DIVIDE: next_state = div_done_all ? ST_LOAD : ST_DIVIDE;
      ST_LOAD: next_state = ST_SAMPLE;
    endcase
  end

  // State register and refresh strobe
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      state <= ST_SAMPLE;
      MON_UPDATE <= 1'b0;
    end
    else
    begin
      state <= next_state;
      MON_UPDATE <= (state == ST_LOAD);
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);

  AST_CH_INDEP: assert property (wr_acc && g_chan[0].hit_off |=> $stable(g_chan[1].off))
    else $error("Channel one write disturbed channel two offset");
  AST_REFRESH: assert property (MON_UPDATE |-> ##47 MON_UPDATE)
    else $error("Outputs not refreshed every 47 cycles");
  AST_ABS_BOTH: assert property ((state == ST_LOAD) && abs_mode |=>
    (MON_CH1_MV >= 0) && (MON_CH2_MV >= 0))
    else $error("Negative output while magnitude mode is set");
  AST_SEL_LOW: assert property ((g_chan[0].sel == RST_SEL) |->
    (g_chan[0].val == VAR_SPEED_FB))
    else $error("Code zero does not route speed feedback");
  AST_SEL_RSVD: assert property ((g_chan[0].sel == 16'(SEL_RESERVED)) |->
    (g_chan[0].val == 0))
    else $error("Reserved code does not read zero");
  AST_SEL_HIGH: assert property ((g_chan[1].sel == SEL_LAST) |->
    (g_chan[1].val == VAR_HALL_W))
    else $error("Last code does not route the third hall value");
  AST_CH1_SIGN: assert property ((state == ST_SAMPLE) |=>
    (g_chan[0].neg_q == $past(g_chan[0].lt)))
    else $error("Channel one sign not taken from variable minus offset");
  AST_CH1_QUOT: assert property ((state == ST_LOAD) && (g_chan[0].den_q != 0) |->
    g_chan[0].quot_ok)
    else $error("Channel one quotient wrong for its scale");
  AST_CH2_SIGN: assert property ((state == ST_SAMPLE) |=>
    (g_chan[1].neg_q == $past(g_chan[1].lt)))
    else $error("Channel two sign not taken from variable minus offset");
  AST_CH2_QUOT: assert property ((state == ST_LOAD) && (g_chan[1].den_q != 0) |->
    g_chan[1].quot_ok)
    else $error("Channel two quotient wrong for its scale");
  AST_SAME_TABLE: assert property ((g_chan[0].sel == g_chan[1].sel) |->
    (g_chan[0].val == g_chan[1].val))
    else $error("Channels decode the same code differently");

  // Bus side: a setup cycle on an unmapped word must flag an error
  // for the access phase that follows, so software sees the miss
  AST_UNMAPPED: assert property (PSEL && !PENABLE && !hit_any |=> PSLVERR)
    else $error("Unmapped access without error response");

  // The refresh strobe is a single-cycle pulse; a longer pulse would
  // make a sampling meter take one reading twice
  AST_UPD_PULSE: assert property (MON_UPDATE |=> !MON_UPDATE)
    else $error("Refresh strobe longer than one cycle");

  // Outputs only move together with the strobe; a meter that samples
  // between strobes must always see the last result
  AST_CH1_HOLD: assert property (!MON_UPDATE |-> $stable(MON_CH1_MV))
    else $error("Channel one output moved between refreshes");
  AST_CH2_HOLD: assert property (!MON_UPDATE |-> $stable(MON_CH2_MV))
    else $error("Channel two output moved between refreshes");

  // A negative nonzero result keeps its sign unless magnitude mode is set
  AST_CH1_NEG: assert property ((state == ST_LOAD) && !abs_mode && g_chan[0].neg_q
    && (g_chan[0].quot != 0) |=> (MON_CH1_MV < 0))
    else $error("Channel one lost the sign of its result");

  // Channel two decodes the reserved code and the first upper code
  // exactly as channel one does
  AST_CH2_RSVD: assert property ((g_chan[1].sel == 16'(SEL_RESERVED)) |->
    (g_chan[1].val == 0))
    else $error("Channel two reserved code does not read zero");
  AST_SEL_NINE: assert property ((g_chan[1].sel == 16'(SEL_RESERVED + 1)) |->
    (g_chan[1].val == VAR_ENC_TURN))
    else $error("First upper code does not route single-turn data");

  // Scenarios worth seeing at least once
  COV_RSVD_CODE: cover property ((state == ST_SAMPLE) && (g_chan[0].sel == 16'(SEL_RESERVED)));
  COV_ABS_LOAD: cover property ((state == ST_LOAD) && abs_mode);
  COV_FULL_SCALE: cover property (MON_UPDATE && (MON_CH1_MV == LIMIT_MV[OUT_W-1:0]));
  COV_NEG_OUT: cover property (MON_UPDATE && (MON_CH2_MV < 0));
  COV_SLVERR: cover property (PSEL && PENABLE && PSLVERR);
endmodule // dams_scaler

// ---- dams_meter.sv ----
// Partner model: an external meter reading both analog monitor outputs
module dams_meter
  import dams_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic upd,
  input wire logic signed [OUT_W-1:0] ch1,
  input wire logic signed [OUT_W-1:0] ch2,
  output logic [OUT_W-1:0] peak
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [OUT_W-1:0] mag1; // Magnitude of channel one reading
  logic [OUT_W-1:0] mag2; // Magnitude of channel two reading
  logic [OUT_W-1:0] next_peak; // Largest magnitude including this reading
  assign mag1 = ch1[OUT_W-1] ? OUT_W'(-ch1) : OUT_W'(ch1);
  assign mag2 = ch2[OUT_W-1] ? OUT_W'(-ch2) : OUT_W'(ch2);
  assign next_peak = (mag1 > peak) ? ((mag2 > mag1) ? mag2 : mag1) : ((mag2 > peak) ? mag2 : peak);
  // Reads only on the update strobe, like a sampling meter would
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      peak <= '0;
    else if (upd)
      peak <= next_peak;
  end
endmodule // dams_meter

// ---- dual_analog_monitor_scaler_bench.sv ----
// Self-checking bench for the dual analog monitor scaler
`define CHK(nm, ex, got) \
  begin n_tests++; if ((got) !== (ex)) begin miscompares++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module dual_analog_monitor_scaler_bench
  import dams_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_SYS, RST_B, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, MON_UPDATE;
  logic [15:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [3:0] PSTRB;
  logic signed [OUT_W-1:0] MON_CH1_MV, MON_CH2_MV;
  logic signed [VAL_W-1:0] var_in [25]; // Index 8 is the reserved code, never routed
  logic [OUT_W-1:0] peak;
  int miscompares, n_tests, seed;
  logic [15:0] ra [7] = '{ADDR_MODE, ADDR_SEL1, ADDR_SEL2, ADDR_OFF1, ADDR_OFF2,
    ADDR_SCL1, ADDR_SCL2};
  dams_scaler i_dams_scaler (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .VAR_SPEED_FB(var_in[0]), .VAR_SPEED_CMD(var_in[1]), .VAR_SPEED_ERR(var_in[2]),
    .VAR_TORQUE_FB(var_in[3]), .VAR_TORQUE_CMD(var_in[4]), .VAR_POS_ERR(var_in[5]),
    .VAR_OVERLOAD(var_in[6]), .VAR_LINK_VOLT(var_in[7]), .VAR_ENC_TURN(var_in[9]),
    .VAR_INERTIA(var_in[10]), .VAR_FOLLOW_ERR(var_in[11]), .VAR_DRV_TEMP1(var_in[12]),
    .VAR_DRV_TEMP2(var_in[13]), .VAR_ENC_TEMP(var_in[14]), .VAR_HALL(var_in[15]),
    .VAR_CUR_U(var_in[16]), .VAR_CUR_V(var_in[17]), .VAR_CUR_W(var_in[18]),
    .VAR_POS_ACT(var_in[19]), .VAR_POS_DMD(var_in[20]), .VAR_CMD_SPEED(var_in[21]),
    .VAR_HALL_U(var_in[22]), .VAR_HALL_V(var_in[23]), .VAR_HALL_W(var_in[24]),
    .MON_CH1_MV(MON_CH1_MV), .MON_CH2_MV(MON_CH2_MV), .MON_UPDATE(MON_UPDATE));
  dams_meter i_dams_meter (.clk(CLK_SYS), .rst_b(RST_B), .upd(MON_UPDATE),
    .ch1(MON_CH1_MV), .ch2(MON_CH2_MV), .peak(peak));
  // Free running system clock, 4 ns period
  initial
  begin
    CLK_SYS = 1'b0;
    forever #2 CLK_SYS = ~CLK_SYS;
  end
  // Prints the counts and the verdict, then stops the run
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // One APB transfer; entered just after a rising edge, leaves one idle cycle
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] rd, output logic err);
    int k;
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    PSTRB <= s;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    k = 0;
    do
    begin
      @(posedge CLK_SYS);
      k++;
    end
    while (PREADY !== 1'b1 && k < 50);
    rd = PRDATA;
    err = PSLVERR;
    if (k >= 50)
    begin
      miscompares++;
      end_of_test();
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK_SYS);
  endtask
  // Waits for the next update strobe, sampled at the falling edge
  task automatic wait_upd();
    int k;
    k = 0;
    do
    begin
      @(negedge CLK_SYS);
      k++;
    end
    while (MON_UPDATE !== 1'b1 && k < 100);
    if (k >= 100)
    begin
      miscompares++;
      end_of_test();
    end
  endtask
  // Reserved and out-of-table codes route zero
  function automatic logic signed [31:0] val_of(int c);
    return (c == SEL_RESERVED || c > 24) ? 32'sh0 : var_in[c];
  endfunction
  // Expected millivolts: (value - offset) * 1000 / scale, limited to 10 V
  function automatic logic signed [15:0] exp_mv(logic signed [31:0] v,
    logic signed [31:0] o, logic [31:0] s, logic [15:0] m);
    logic signed [63:0] d;
    logic [63:0] q;
    d = 64'(v) - 64'(o);
    q = (d < 0) ? -d : d;
    q = (s == 32'h0) ? 64'h2710 : q * 64'h3e8 / s;
    if (q > 64'h2710)
      q = 64'h2710;
    return (d < 0 && m != MODE_ABS) ? -16'(q) : 16'(q);
  endfunction
  // Main sequence: registers first, then every selector code and random settings
  initial
  begin
    logic [31:0] rd, o1, o2, s1, s2;
    logic err;
    logic [15:0] m;
    int c1, c2;
    {RST_B, PSEL, PENABLE, PWRITE, PADDR, PWDATA, PSTRB} = '0;
    foreach (var_in[i]) var_in[i] = '0;
    seed = $urandom(31);
    repeat (5) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    @(posedge CLK_SYS);
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, ra[i], 32'h0, 4'hf, rd, err);
      `CHK("reset value", (i >= 5) ? 32'h1 : 32'h0, rd)
      o1 = $urandom();
      apb(1'b1, ra[i], o1, 4'hf, rd, err);
      apb(1'b0, ra[i], 32'h0, 4'hf, rd, err);
      `CHK("readback", o1 & ((i < 3) ? 32'h0000ffff : 32'hffffffff), rd)
      `CHK("mapped error", 1'b0, err)
    end
    // Partial lane write and an unmapped place
    apb(1'b1, ADDR_OFF1, 32'hffffffff, 4'hf, rd, err);
    apb(1'b1, ADDR_OFF1, 32'h0, 4'h1, rd, err);
    apb(1'b0, ADDR_OFF1, 32'h0, 4'hf, rd, err);
    `CHK("lane write", 32'hffffff00, rd)
    apb(1'b0, 16'h0000, 32'h0, 4'hf, rd, err);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    for (int n = 0; n < 40; n++)
    begin
      c1 = (n < 25) ? n : $urandom_range(0, 31);
      c2 = (n < 25) ? 24 - n : $urandom_range(0, 31);
      m = 16'($urandom_range(0, 2));
      o1 = $urandom_range(0, 2000) - 1000;
      o2 = $urandom_range(0, 2000) - 1000;
      s1 = (n == 3) ? 32'h0 : $urandom_range(1, 3000);
      s2 = $urandom_range(1, 3000);
      if (n == 4)
        o1 = 32'h80000000;
      if (n == 5)
        o2 = 32'h7fffffff;
      foreach (var_in[i]) var_in[i] <= $urandom_range(0, 40000) - 20000;
      apb(1'b1, ADDR_MODE, 32'(m), 4'hf, rd, err);
      apb(1'b1, ADDR_SEL1, 32'(c1), 4'hf, rd, err);
      apb(1'b1, ADDR_SEL2, 32'(c2), 4'hf, rd, err);
      apb(1'b1, ADDR_OFF1, o1, 4'hf, rd, err);
      apb(1'b1, ADDR_OFF2, o2, 4'hf, rd, err);
      apb(1'b1, ADDR_SCL1, s1, 4'hf, rd, err);
      apb(1'b1, ADDR_SCL2, s2, 4'hf, rd, err);
      wait_upd();
      wait_upd();
      `CHK("channel one", exp_mv(val_of(c1), o1, s1, m), MON_CH1_MV)
      `CHK("channel two", exp_mv(val_of(c2), o2, s2, m), MON_CH2_MV)
      @(posedge CLK_SYS);
    end
    `CHK("meter peak in range", 1'b1, peak <= 16'h2710)
    end_of_test();
  end
endmodule // dual_analog_monitor_scaler_bench
